// [sim/tag_block_password_protection_tb_top.sv]
// Self-checking bench for the block protection logic
`timescale 1ns/1ps
module tag_block_password_protection_tb_top;
  import tbp_pkg::*;
  logic              clk_i, rst_n_i, req_valid, req_sys, req_extra, rsp_valid, rsp_pv, ok;
  logic              r_pv;
  tbp_cmd_t          req_cmd;
  logic [5:0]        req_addr;
  logic [31:0]       req_data, rsp_data, r_data;
  logic [31:0]       mem [64];
  logic [31:0]       pw [4];
  logic [4:0]        prot_m [4];
  logic [1:0]        rsp_err, presented, r_err;
  logic [7:0]        rsp_prot, r_prot;
  int                err_count, n_checks, seed, i, k;

  tbp_protect #(.N_USER(64)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid),
    .req_cmd_i(req_cmd), .req_sys_area_i(req_sys), .req_addr_i(req_addr), .req_data_i(req_data),
    .req_extra_i(req_extra), .rsp_valid_o(rsp_valid), .rsp_err_o(rsp_err), .rsp_data_o(rsp_data),
    .rsp_prot_o(rsp_prot), .rsp_prot_valid_o(rsp_pv), .presented_o(presented));
  tbp_reader_model rdr (.clk_i(clk_i), .req_valid_o(req_valid), .req_cmd_o(req_cmd),
    .req_sys_area_o(req_sys), .req_addr_o(req_addr), .req_data_o(req_data), .req_extra_o(req_extra));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ==========================================================================
  // Expectation and checking helpers
  // ==========================================================================
  function automatic logic exp_ok(logic [4:0] p, logic [1:0] pr, logic wr);
    if (p == 5'h00) return 1'b1;
    if (p == 5'h01) return !wr;
    if (p[2:0] == 3'h7 && p[4:3] != 2'h0) return !wr && pr == p[4:3];
    return 1'b0;
  endfunction

  task automatic check(string name, logic [47:0] seen, logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One request, answer captured in the cycle it stands
  task automatic xfer(tbp_cmd_t c, logic s, logic [5:0] a, logic [31:0] d, logic x);
    rdr.send(c, s, a, d, x);
    @(negedge clk_i);
    rdr.idle();
    {r_err, r_data, r_prot, r_pv} = {rsp_err, rsp_data, rsp_prot, rsp_pv};
    check("rsp_valid", rsp_valid, 1);
    @(negedge clk_i);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    test_done();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    seed = 30246;
    rst_n_i = 1'b0;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i) rst_n_i = 1'b1;
    for (i = 0; i < 68; i++) begin
      xfer(TBP_CMD_STATUS, i >= 64, 6'(i % 64), 0, 0);
      check("prot0", {r_pv, r_prot}, 9'h100);
    end
    check("pres0", presented, 0);
    $display("test reset_state done");
    for (i = 0; i < 64; i++) begin
      mem[i] = $random(seed);
      xfer(TBP_CMD_WRITE, 0, 6'(i), mem[i], 0);
      check("wr_err", r_err, ERR_NONE);
    end
    for (i = 0; i < 64; i++) begin
      xfer(TBP_CMD_READ, 0, 6'(i), $random(seed), 1);
      check("rd", {r_pv, r_prot, r_data}, {9'h100, mem[i]});
    end
    $display("test open_blocks done");
    for (i = 1; i < 4; i++) begin
      pw[i] = $random(seed);
      xfer(TBP_CMD_WRITE, 1, 6'(i), pw[i], 0);
      check("pw_wr", r_err, ERR_NONE);
    end
    xfer(TBP_CMD_WRITE, 1, 6'h05, 0, 0);
    check("sys_addr", r_err, ERR_ADDRESS);
    // Lock one block per link code; bit 0 sent low must still end up set
    for (k = 0; k < 4; k++) begin
      prot_m[k] = (k == 0) ? 5'h01 : {2'(k), 3'h7};
      xfer(TBP_CMD_LOCK, 0, 6'(4 * k), {27'h0, prot_m[k][4:1], 1'b0}, 0);
      check("lock", r_err, ERR_NONE);
      xfer(TBP_CMD_LOCK, 0, 6'(4 * k), 0, 0);
      check("relock", r_err, ERR_LOCKED);
      xfer(TBP_CMD_STATUS, 0, 6'(4 * k), 0, 0);
      check("field", {r_pv, r_prot}, {4'h8, prot_m[k]});
    end
    // Wrong password first, then each password in turn
    for (k = 0; k < 4; k++) begin
      xfer(TBP_CMD_PRESENT, 1, 6'(k == 0 ? 1 : k), k == 0 ? ~pw[1] : pw[k], 0);
      check("pres_err", r_err, k == 0 ? ERR_DENIED : ERR_NONE);
      check("pres", presented, k);
      for (i = 0; i < 4; i++) begin
        ok = exp_ok(prot_m[i], 2'(k), 1'b0);
        xfer(TBP_CMD_READ, 0, 6'(4 * i), 0, 0);
        check("lk_rd", {r_err, r_data}, ok ? {ERR_NONE, mem[4 * i]} : {ERR_DENIED, 32'h0});
        xfer(TBP_CMD_WRITE, 0, 6'(4 * i), $random(seed), 0);
        check("lk_wr", r_err, exp_ok(prot_m[i], 2'(k), 1'b1) ? ERR_NONE : ERR_DENIED);
      end
    end
    xfer(TBP_CMD_LOCK, 1, 6'h02, 0, 0);
    check("pw_lock", r_err, ERR_NONE);
    xfer(TBP_CMD_WRITE, 1, 6'h02, 0, 0);
    check("pw_lk", r_err, ERR_DENIED);
    $display("test protection done");
    // Back-to-back reads, then a power loss in mid-run
    rdr.send(TBP_CMD_READ, 0, 6'h01, 0, 0);
    @(negedge clk_i);
    rdr.send(TBP_CMD_READ, 0, 6'h02, 0, 1);
    check("b2b1", {rsp_valid, rsp_data}, {1'b1, mem[1]});
    @(negedge clk_i);
    rdr.idle();
    check("b2b2", {rsp_pv, rsp_data}, {1'b1, mem[2]});
    rst_n_i = 1'b0;
    @(negedge clk_i);
    rst_n_i = 1'b1;
    check("pres_rst", presented, 0);
    xfer(TBP_CMD_STATUS, 0, 6'h04, 0, 0);
    check("prot_rst", {r_pv, r_prot}, 9'h100);
    $display("test back_to_back_reset done");
    test_done();
  end
endmodule

// [sim/tbp_reader_model.sv]
// Reader model: drives requests on the block's request port
`timescale 1ns/1ps
module tbp_reader_model
  import tbp_pkg::*;
(
  input  wire logic                       clk_i,
  output logic                            req_valid_o,
  output tbp_pkg::tbp_cmd_t               req_cmd_o,
  output logic                            req_sys_area_o,
  output logic [tbp_pkg::ADDR_W-1:0]      req_addr_o,
  output logic [tbp_pkg::DATA_W-1:0]      req_data_o,
  output logic                            req_extra_o
);
  // Quiet bus at time zero
  initial begin
    {req_valid_o, req_sys_area_o, req_addr_o, req_data_o, req_extra_o} = '0;
    req_cmd_o = TBP_CMD_READ;
  end

  // Called just after a falling edge; valid stays up until idle
  task automatic send(tbp_cmd_t c, logic s, logic [5:0] a, logic [31:0] d, logic x);
    req_cmd_o      = c;
    req_sys_area_o = s;
    req_addr_o     = a;
    req_extra_o    = x;
    // Only legal field codes are ever sent on a lock
    req_data_o = (c == TBP_CMD_LOCK && d[4:1] != 4'h0 && !(d[2:1] == 2'h3 && d[4:3] != 2'h0)) ? '0 : d;
    req_valid_o = 1'b1;
  endtask

  // Released lines other than the command do not keep their last value
  task automatic idle();
    req_valid_o    = 1'b0;
    req_data_o     = ~req_data_o;
    req_addr_o     = ~req_addr_o;
    req_extra_o    = ~req_extra_o;
    req_sys_area_o = ~req_sys_area_o;
  endtask
endmodule

// [verilog/tbp_pkg.sv]
// Package: constants and types for the tag block password protection logic
package tbp_pkg;

  // ==========================================================================
  // Protection field layout
  // ==========================================================================
  localparam int unsigned LOCK_POS   = 0;
  localparam int unsigned RW_LO      = 1;
  localparam int unsigned LINK_LO    = 3;
  localparam int unsigned PROT_W     = 5;
  localparam logic [4:0]  PROT_RST   = 5'h00;
  localparam logic [1:0]  RW_PROTECT = 2'h3;
  localparam logic [1:0]  RW_OPEN    = 2'h0;
  localparam logic [1:0]  LINK_NONE  = 2'h0;

  // ==========================================================================
  // Memory geometry
  // ==========================================================================
  localparam int unsigned USER_BLOCKS = 64;
  localparam int unsigned SYS_BLOCKS  = 4;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned ADDR_W      = 6;
  localparam logic [5:0]  KILL_ADDR   = 6'h00;

  // ==========================================================================
  // Commands and answers
  // ==========================================================================
  typedef enum logic [2:0] {
    TBP_CMD_READ,
    TBP_CMD_WRITE,
    TBP_CMD_LOCK,
    TBP_CMD_PRESENT,
    TBP_CMD_STATUS
  } tbp_cmd_t;

  localparam logic [1:0] ERR_NONE     = 2'h0;
  localparam logic [1:0] ERR_DENIED   = 2'h1;
  localparam logic [1:0] ERR_LOCKED   = 2'h2;
  localparam logic [1:0] ERR_ADDRESS  = 2'h3;

endpackage

// [verilog/tbp_protect.sv]
// Per-block protection fields, password presentation and access arbitration
`timescale 1ns/1ps
//
// Functional notes
// - Each block keeps five protection bits: lock, two access, two link; upper read zero.
// - Access bits take effect only while the lock bit is one.
// - Link bits 01, 10, 11 tie passwords one to three; 00 ties none.
// - Unlocked with both fields zero: block fully readable and writable.
// - Locked, access 11, linked: no access until presented, then read only.
// - Locked with both fields zero: readable, never writable.
// - Other combinations are reserved; reader must not program them.
// - Protection field returned by extra-info reads and security status requests.
// - Four system blocks: kill code, then passwords one to three, each protected.
// - Write-password stores 32 bits into a system block if rights allow.
// - Lock request loads field bits four to one and forces the lock bit.
// - Locked fields change only when reset clears them; a lock request to them returns an error.
// - Area select bit: zero for user blocks, one for system blocks.
// - Matching presentation grants rights to all linked blocks until next presentation or reset.
// - After power-up no password counts as presented.
// - User memory is 64 blocks of 32 bits, each with a field.
// - A permitted user write replaces all 32 bits of the block.

module tbp_protect #(
  parameter int unsigned N_USER = tbp_pkg::USER_BLOCKS
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_n_i,
  input  wire logic                          req_valid_i,
  input  wire tbp_pkg::tbp_cmd_t             req_cmd_i,
  input  wire logic                          req_sys_area_i,
  input  wire logic [tbp_pkg::ADDR_W-1:0]    req_addr_i,
  input  wire logic [tbp_pkg::DATA_W-1:0]    req_data_i,
  input  wire logic                          req_extra_i,
  output logic                               rsp_valid_o,
  output logic [1:0]                         rsp_err_o,
  output logic [tbp_pkg::DATA_W-1:0]         rsp_data_o,
  output logic [7:0]                         rsp_prot_o,
  output logic                               rsp_prot_valid_o,
  output logic [1:0]                         presented_o
);
  import tbp_pkg::*;

  // ==========================================================================
  // Storage
  // ==========================================================================
  logic [DATA_W-1:0] user_mem [N_USER];
  logic [DATA_W-1:0] sys_mem  [SYS_BLOCKS];
  logic [PROT_W-1:0] user_prot [N_USER];
  logic [PROT_W-1:0] sys_prot  [SYS_BLOCKS];
  logic [1:0]        presented;                         // Index of presented password, 0 none

  // ==========================================================================
  // Address decode and field selection
  // ==========================================================================
  wire               sys_sel   = req_sys_area_i;
  // User bound compared one bit wider: 64 blocks would wrap to zero in an address-wide constant
  wire               addr_ok   = sys_sel ? (req_addr_i < ADDR_W'(SYS_BLOCKS))
                                         : ({1'b0, req_addr_i} < (ADDR_W + 1)'(N_USER));
  wire [1:0]         sys_idx   = req_addr_i[1:0];
  wire [PROT_W-1:0]  cur_prot  = !addr_ok ? PROT_RST
                               : sys_sel ? sys_prot[sys_idx] : user_prot[req_addr_i];
  wire [DATA_W-1:0]  cur_data  = !addr_ok ? '0
                               : sys_sel ? sys_mem[sys_idx] : user_mem[req_addr_i];
  wire               f_lock    = cur_prot[LOCK_POS];
  wire [1:0]         f_rw      = cur_prot[RW_LO +: 2];
  wire [1:0]         f_link    = cur_prot[LINK_LO +: 2];

  // Access decode; reserved combinations are treated as fully denied for safety
  wire               is_open   = !f_lock && f_rw == RW_OPEN && f_link == LINK_NONE;
  wire               is_ro     = f_lock && f_rw == RW_OPEN && f_link == LINK_NONE;
  wire               is_pw     = f_lock && f_rw == RW_PROTECT && f_link != LINK_NONE;
  wire               link_hit  = is_pw && presented == f_link;
  wire               can_read  = is_open || is_ro || link_hit;
  wire               can_write = is_open;

  // Password match for presentation; kill code block is not a password
  wire               pw_match  = sys_sel && addr_ok && sys_idx != KILL_ADDR[1:0]
                                 && sys_mem[sys_idx] == req_data_i;

  wire               do_read   = req_valid_i && req_cmd_i == TBP_CMD_READ;
  wire               do_write  = req_valid_i && req_cmd_i == TBP_CMD_WRITE;
  wire               do_lock   = req_valid_i && req_cmd_i == TBP_CMD_LOCK;
  wire               do_pres   = req_valid_i && req_cmd_i == TBP_CMD_PRESENT;
  wire               do_stat   = req_valid_i && req_cmd_i == TBP_CMD_STATUS;
  wire               wr_ok     = do_write && addr_ok && can_write;
  wire               lock_ok   = do_lock && addr_ok && !f_lock;
  wire [PROT_W-1:0]  lock_val  = {req_data_i[LINK_LO +: 2], req_data_i[RW_LO +: 2], 1'b1};

  // Answer code selection
  wire [1:0]         next_err  = !addr_ok                 ? ERR_ADDRESS
                               : (do_read && !can_read)    ? ERR_DENIED
                               : (do_write && !can_write)  ? ERR_DENIED
                               : (do_lock && f_lock)       ? ERR_LOCKED
                               : (do_pres && !pw_match)    ? ERR_DENIED
                               : ERR_NONE;
  wire               next_pv   = addr_ok && (do_stat || (do_read && req_extra_i));

  // ==========================================================================
  // Data arrays: no reset, contents are nonvolatile in the real part
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (wr_ok && !sys_sel) begin
      user_mem[req_addr_i] <= req_data_i;
    end
    if (wr_ok && sys_sel) begin
      sys_mem[sys_idx] <= req_data_i;
    end
  end

  // ==========================================================================
  // Protection fields: cleared by reset, otherwise only written while still unlocked
  // ==========================================================================
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < N_USER; i++) begin
        user_prot[i] <= PROT_RST;
      end
      for (int j = 0; j < SYS_BLOCKS; j++) begin
        sys_prot[j] <= PROT_RST;
      end
    end else if (lock_ok) begin
      if (sys_sel) begin
        sys_prot[sys_idx] <= lock_val;
      end else begin
        user_prot[req_addr_i] <= lock_val;
      end
    end
  end

  // ==========================================================================
  // Presented password: a new presentation replaces the old, a failed one clears it
  // ==========================================================================
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      presented <= 2'h0;
    end else if (do_pres) begin
      presented <= pw_match ? sys_idx : 2'h0;
    end
  end

  // ==========================================================================
  // Answer registers, one cycle after the request
  // ==========================================================================
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp_valid_o      <= 1'b0;
      rsp_err_o        <= ERR_NONE;
      rsp_data_o       <= '0;
      rsp_prot_o       <= 8'h00;
      rsp_prot_valid_o <= 1'b0;
    end else begin
      rsp_valid_o      <= req_valid_i;
      rsp_err_o        <= req_valid_i ? next_err : ERR_NONE;
      rsp_data_o       <= (do_read && addr_ok && can_read) ? cur_data : '0;
      rsp_prot_o       <= next_pv ? {3'h0, cur_prot} : 8'h00;
      rsp_prot_valid_o <= next_pv;
    end
  end

  assign presented_o = presented;

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_open_write;
    @(posedge clk_i) disable iff (!rst_n_i)
    do_write && addr_ok && is_open |=> rsp_err_o == ERR_NONE;
  endproperty
  a_open_write: assert property (p_open_write) else $error("open block write refused");

  property p_ro_write;
    @(posedge clk_i) disable iff (!rst_n_i)
    do_write && addr_ok && f_lock |=> rsp_err_o == ERR_DENIED;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("locked block write accepted");

  property p_pw_read;
    @(posedge clk_i) disable iff (!rst_n_i)
    do_read && addr_ok && is_pw && presented != f_link |=> rsp_err_o == ERR_DENIED && rsp_data_o == '0;
  endproperty
  a_pw_read: assert property (p_pw_read) else $error("read without password allowed");

  property p_lock_err;
    @(posedge clk_i) disable iff (!rst_n_i)
    do_lock && addr_ok && f_lock |=> rsp_err_o == ERR_LOCKED;
  endproperty
  a_lock_err: assert property (p_lock_err) else $error("relock not reported");

  property p_lock_stable;
    @(posedge clk_i) disable iff (!rst_n_i)
    req_valid_i && addr_ok && f_lock && !sys_sel ##1 1 |-> user_prot[$past(req_addr_i)] == $past(cur_prot);
  endproperty
  a_lock_stable: assert property (p_lock_stable) else $error("locked field changed");

  property p_lock_set;
    @(posedge clk_i) disable iff (!rst_n_i)
    lock_ok && !sys_sel |=> user_prot[$past(req_addr_i)][LOCK_POS] == 1'b1;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock bit not forced");

  property p_present;
    @(posedge clk_i) disable iff (!rst_n_i)
    do_pres && pw_match |=> presented == $past(sys_idx);
  endproperty
  a_present: assert property (p_present) else $error("presentation not recorded");

  property p_prot_zero;
    @(posedge clk_i) disable iff (!rst_n_i)
    rsp_prot_valid_o |-> rsp_prot_o[7:5] == 3'h0 && rsp_valid_o;
  endproperty
  a_prot_zero: assert property (p_prot_zero) else $error("upper field bits not zero");

  property p_extra;
    @(posedge clk_i) disable iff (!rst_n_i)
    do_read && req_extra_i && addr_ok |=> rsp_prot_valid_o;
  endproperty
  a_extra: assert property (p_extra) else $error("field missing on extra read");

  // ==========================================================================
  // Storage, answer and reset checks
  // ==========================================================================
  // Data checks compare against whatever the block held, written or not, although the arrays have no reset

  property p_sys_write;
    @(posedge clk_i) disable iff (!rst_n_i)
    do_write && sys_sel && addr_ok && !is_open |=> rsp_err_o == ERR_DENIED;
  endproperty
  a_sys_write: assert property (p_sys_write) else $error("protected password write accepted");

  property p_sys_store;
    @(posedge clk_i) disable iff (!rst_n_i)
    do_write && sys_sel && addr_ok && is_open |=> sys_mem[$past(sys_idx)] == $past(req_data_i);
  endproperty
  a_sys_store: assert property (p_sys_store) else $error("password value not stored");

  property p_user_store;
    @(posedge clk_i) disable iff (!rst_n_i)
    do_write && !sys_sel && addr_ok && is_open |=> user_mem[$past(req_addr_i)] == $past(req_data_i);
  endproperty
  a_user_store: assert property (p_user_store) else $error("user block not replaced");

  property p_keep_data;
    @(posedge clk_i) disable iff (!rst_n_i)
    do_write && !sys_sel && addr_ok && !can_write |=> user_mem[$past(req_addr_i)] == $past(cur_data);
  endproperty
  a_keep_data: assert property (p_keep_data) else $error("refused write changed data");

  property p_err_data;
    @(posedge clk_i) disable iff (!rst_n_i)
    rsp_valid_o && rsp_err_o != ERR_NONE |-> rsp_data_o == '0;
  endproperty
  a_err_data: assert property (p_err_data) else $error("data returned with error");

  property p_ro_read;
    @(posedge clk_i) disable iff (!rst_n_i)
    do_read && addr_ok && is_ro |=> rsp_err_o == ERR_NONE && rsp_data_o == $past(cur_data);
  endproperty
  a_ro_read: assert property (p_ro_read) else $error("read only block not readable");

  property p_pw_hit;
    @(posedge clk_i) disable iff (!rst_n_i)
    do_read && addr_ok && link_hit |=> rsp_err_o == ERR_NONE && rsp_data_o == $past(cur_data);
  endproperty
  a_pw_hit: assert property (p_pw_hit) else $error("presented password read refused");

  property p_pres_fail;
    @(posedge clk_i) disable iff (!rst_n_i)
    do_pres && !pw_match |=> presented == 2'h0 && rsp_err_o == ERR_DENIED;
  endproperty
  a_pres_fail: assert property (p_pres_fail) else $error("failed presentation kept rights");

  property p_lock_sys;
    @(posedge clk_i) disable iff (!rst_n_i)
    lock_ok && sys_sel |=> sys_prot[$past(sys_idx)] == $past(lock_val);
  endproperty
  a_lock_sys: assert property (p_lock_sys) else $error("password field not loaded");

  property p_addr_err;
    @(posedge clk_i) disable iff (!rst_n_i)
    req_valid_i && !addr_ok |=> rsp_err_o == ERR_ADDRESS && !rsp_prot_valid_o;
  endproperty
  a_addr_err: assert property (p_addr_err) else $error("bad address not reported");

  property p_status;
    @(posedge clk_i) disable iff (!rst_n_i)
    do_stat && addr_ok |=> rsp_prot_valid_o && rsp_prot_o[4:0] == $past(cur_prot);
  endproperty
  a_status: assert property (p_status) else $error("status field wrong");

  // Deliberately not disabled by reset: it watches the reset itself
  property p_reset_clear;
    @(posedge clk_i)
    !rst_n_i |-> presented == 2'h0 && !rsp_valid_o;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("rights survive reset");

  c_present_ok: cover property (@(posedge clk_i) disable iff (!rst_n_i) do_pres && pw_match);
  c_addr_err:   cover property (@(posedge clk_i) disable iff (!rst_n_i) req_valid_i && !addr_ok);
  c_pw_read:    cover property (@(posedge clk_i) disable iff (!rst_n_i) do_read && link_hit);
  c_relock:     cover property (@(posedge clk_i) disable iff (!rst_n_i) do_lock && f_lock);

endmodule
